// ---- hdl/fwl_pkg.sv ----
/*
  Package for the firmware RAM loader: register offsets, control bit positions,
  RAM geometry, timing constants and the request carrier.
  Assumes a 20 MHz PCI-side clock and a synchronous active-low reset.
*/
package fwl_pkg;

  // ==========================================================================
  // Register map
  localparam logic [2:0] FWL_OFS_DATA_ADDR = 3'h0;
  localparam logic [2:0] FWL_OFS_CONTROL   = 3'h4;

  // ==========================================================================
  // Control register fields
  localparam int FWL_BIT_ERR      = 0;
  localparam int FWL_BIT_PROGRAM  = 1;
  localparam int FWL_BIT_DONE     = 2;
  localparam int FWL_BIT_ADDR_RST = 3;

  localparam logic [31:0] FWL_DATA_READ_VALUE = 32'hFFFFFFFF;
  localparam logic [31:0] FWL_CONTROL_RESET   = 32'h00000000;

  // ==========================================================================
  // RAM geometry: 192K words of 16 bits
  localparam int FWL_RAM_WORDS = 196608;
  localparam int FWL_WORD_W    = 16;
  localparam int FWL_ADDR_W    = 18;
  localparam logic [FWL_ADDR_W-1:0] FWL_ADDR_RESET = 18'h00000;
  localparam logic [FWL_ADDR_W-1:0] FWL_ADDR_LAST  = 18'h2FFFF;

  // ==========================================================================
  // FIFO and timing
  localparam int FWL_FIFO_DEPTH = 16;
  localparam int FWL_CLK_MHZ    = 20;
  // Retry time-out: longest time a held write may wait, in microseconds
  localparam int FWL_RETRY_TIMEOUT_US = 10;
  localparam int FWL_RETRY_TIMEOUT_CYC = FWL_RETRY_TIMEOUT_US * FWL_CLK_MHZ;
  localparam logic [7:0] FWL_RETRY_TIMEOUT_C = 8'(FWL_RETRY_TIMEOUT_CYC);
  localparam logic [7:0] FWL_WAIT_RESET      = 8'h00;

  // ==========================================================================
  // Carrier for one RAM write request
  typedef struct packed {
    logic [FWL_ADDR_W-1:0] addr;
    logic [FWL_WORD_W-1:0] data;
  } fwl_req_s;

  localparam int FWL_REQ_W = FWL_ADDR_W + FWL_WORD_W;

endpackage

// ---- hdl/fwl_fifo.sv ----
/*
  Synchronous FIFO with parameter width and depth, valid/ready on both sides.
  Assumes a single clock and a synchronous active-low reset.
*/
`timescale 1ns/1ns
module fwl_fifo #(
  parameter int WIDTH = 34,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count != (PW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem[rd_ptr];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule

// ---- hdl/fwl_loader.sv ----
/*
  Firmware RAM loader: two-register I/O window, address autoincrement, a
  request FIFO before the program RAM, media core reset hold and error flag.
  Assumes the I/O window decode of the PCI target is done outside; this block
  sees a one-cycle access strobe and answers with ack or retry in that cycle.
  The RAM write port stalls during the clear sweep; clr_busy high backs up into the FIFO.
*/
// How it works
// - Global reset clears RAM and loader state
// - Media core held reset during loading
// - Done bit 2 at 04h ends loading
// - Program RAM is 192K sixteen-bit words
// - Decode only offsets 00h and 04h
// - With address-reset set, write sets address
// - Address-reset self-clears; later writes are data
// - Each data write stores one word
// - Load address increments after each word
// - Buffer writes; retry while buffer full
// - Retry time-out discards data, sets error
// - Data register reads return all ones
// - Address-reset is write-only bit 3
// - Program bit 1 marks loading in progress
// - Error bit 0 cleared by control read
`timescale 1ns/1ns
module fwl_loader
  import fwl_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  reset_n_i,
  input  wire logic                  global_reset_in_n_i,
  input  wire logic                  io_sel_i,
  input  wire logic                  io_write_i,
  input  wire logic [2:0]            io_addr_i,
  input  wire logic [31:0]           io_wdata_i,
  input  wire logic [3:0]            io_be_n_i,
  output logic      [31:0]           io_rdata_o,
  output logic                       io_ack_o,
  output logic                       io_retry_o,
  output logic                       io_unmapped_o,
  output logic                       core_reset_n_o,
  output logic                       programming_o,
  output logic                       load_error_o,
  input  wire logic [FWL_ADDR_W-1:0] core_raddr_i,
  output logic      [FWL_WORD_W-1:0] core_rdata_o
);

  // ==========================================================================
  // Global reset synchroniser
  logic global_reset_in_meta_n;
  logic global_reset_in_sync_n;
  logic rst_n;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      global_reset_in_meta_n <= 1'b0;
      global_reset_in_sync_n <= 1'b0;
    end else begin
      global_reset_in_meta_n <= global_reset_in_n_i;
      global_reset_in_sync_n <= global_reset_in_meta_n;
    end
  end

  assign rst_n = reset_n_i && global_reset_in_sync_n;

  // ==========================================================================
  // Access decode
  logic hit_data;
  logic hit_ctrl;
  logic wr_data;
  logic wr_ctrl;
  logic rd_ctrl;
  logic fifo_in_ready;
  logic data_word_wr;

  assign hit_data      = io_sel_i && (io_addr_i == FWL_OFS_DATA_ADDR);
  assign hit_ctrl      = io_sel_i && (io_addr_i == FWL_OFS_CONTROL);
  assign io_unmapped_o = io_sel_i && !hit_data && !hit_ctrl;
  assign wr_data       = hit_data && io_write_i;
  assign wr_ctrl       = hit_ctrl && io_write_i && !io_be_n_i[0];
  assign rd_ctrl       = hit_ctrl && !io_write_i;

  // ==========================================================================
  // Control state
  logic                  addr_rst;
  logic                  program_flag;
  logic                  load_done;
  logic                  err_flag;
  logic [FWL_ADDR_W-1:0] load_addr;
  logic [7:0]            wait_cnt;
  logic                  timeout;

  assign data_word_wr = wr_data && !addr_rst && fifo_in_ready;
  assign timeout      = wr_data && !addr_rst && !fifo_in_ready && (wait_cnt == FWL_RETRY_TIMEOUT_C - 8'h01);

  // A data-word write is retried while the FIFO is full, until the time-out drops it
  assign io_retry_o = wr_data && !addr_rst && !fifo_in_ready && !timeout;
  assign io_ack_o   = io_sel_i && !io_retry_o;

  always_ff @(posedge clk_i) begin
    if (!rst_n) begin
      addr_rst <= 1'b0;
    end else if (wr_data && addr_rst) begin
      addr_rst <= 1'b0;
    end else if (wr_ctrl && io_wdata_i[FWL_BIT_ADDR_RST]) begin
      addr_rst <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n) begin
      load_addr <= FWL_ADDR_RESET;
    end else if (wr_data && addr_rst) begin
      load_addr <= io_wdata_i[FWL_ADDR_W-1:0];
    end else if (data_word_wr) begin
      load_addr <= (load_addr == FWL_ADDR_LAST) ? FWL_ADDR_RESET : load_addr + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n) begin
      program_flag <= 1'b0;
      load_done    <= 1'b0;
    end else if (wr_ctrl) begin
      if (io_wdata_i[FWL_BIT_PROGRAM]) begin
        program_flag <= 1'b1;
        load_done    <= 1'b0;
      end
      if (io_wdata_i[FWL_BIT_DONE]) begin
        load_done    <= 1'b1;
        program_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n) begin
      wait_cnt <= FWL_WAIT_RESET;
    end else if (io_retry_o) begin
      wait_cnt <= wait_cnt + 8'h01;
    end else if (wr_data) begin
      wait_cnt <= FWL_WAIT_RESET;
    end
  end

  // Set wins over the read that clears it
  always_ff @(posedge clk_i) begin
    if (!rst_n) begin
      err_flag <= 1'b0;
    end else if (timeout) begin
      err_flag <= 1'b1;
    end else if (rd_ctrl) begin
      err_flag <= 1'b0;
    end
  end

  assign core_reset_n_o = load_done && !program_flag;
  assign programming_o  = program_flag;
  assign load_error_o   = err_flag;

  // ==========================================================================
  // Read data
  always_ff @(posedge clk_i) begin
    if (!rst_n) begin
      io_rdata_o <= FWL_DATA_READ_VALUE;
    end else if (hit_data) begin
      io_rdata_o <= FWL_DATA_READ_VALUE;
    end else if (hit_ctrl) begin
      io_rdata_o <= {31'h00000000, err_flag};
    end else begin
      io_rdata_o <= FWL_CONTROL_RESET;
    end
  end

  // ==========================================================================
  // Request FIFO and program RAM
  fwl_req_s fifo_in;
  fwl_req_s fifo_out;
  logic     fifo_out_valid;
  logic     clr_busy;
  logic [FWL_ADDR_W-1:0] clr_addr;

  assign fifo_in.addr = load_addr;
  assign fifo_in.data = io_wdata_i[FWL_WORD_W-1:0];

  fwl_fifo #(
    .WIDTH (FWL_REQ_W),
    .DEPTH (FWL_FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .reset_n_i   (rst_n),
    .in_data_i   (fifo_in),
    .in_valid_i  (data_word_wr),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_out),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (!clr_busy)
  );

  logic [FWL_WORD_W-1:0] ram [FWL_RAM_WORDS];

  // After reset the RAM is swept to zero; writes queue in the FIFO meanwhile
  always_ff @(posedge clk_i) begin
    if (!rst_n) begin
      clr_busy <= 1'b1;
      clr_addr <= FWL_ADDR_RESET;
    end else if (clr_busy) begin
      clr_addr <= clr_addr + 1'b1;
      if (clr_addr == FWL_ADDR_LAST) begin
        clr_busy <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (clr_busy) begin
      ram[clr_addr] <= '0;
    end else if (fifo_out_valid) begin
      ram[fifo_out.addr] <= fifo_out.data;
    end
  end

  always_ff @(posedge clk_i) begin
    core_rdata_o <= ram[core_raddr_i];
  end

  // ==========================================================================
  // Checks
  chk_data_reads_ones: assert property (@(posedge clk_i) disable iff (!rst_n)
    hit_data && !io_write_i |=> io_rdata_o == FWL_DATA_READ_VALUE)
    else $error("data register read not all ones");
  chk_addr_rst_clear: assert property (@(posedge clk_i) disable iff (!rst_n)
    wr_data && addr_rst |=> !addr_rst && load_addr == $past(io_wdata_i[FWL_ADDR_W-1:0]))
    else $error("address write did not load address");
  chk_addr_increment: assert property (@(posedge clk_i) disable iff (!rst_n)
    data_word_wr && load_addr != FWL_ADDR_LAST |=> load_addr == $past(load_addr) + 1'b1)
    else $error("load address did not increment");
  chk_core_held: assert property (@(posedge clk_i) disable iff (!rst_n)
    program_flag |-> !core_reset_n_o)
    else $error("core out of reset while programming");
  chk_done_release: assert property (@(posedge clk_i) disable iff (!rst_n)
    wr_ctrl && io_wdata_i[FWL_BIT_DONE] |=> core_reset_n_o)
    else $error("done did not release core");
  chk_core_needs_done: assert property (@(posedge clk_i) disable iff (!rst_n)
    core_reset_n_o |-> load_done)
    else $error("core released without done");
  chk_retry_when_full: assert property (@(posedge clk_i) disable iff (!rst_n)
    wr_data && !addr_rst && !fifo_in_ready && wait_cnt != FWL_RETRY_TIMEOUT_C - 8'h01 |-> io_retry_o && !io_ack_o)
    else $error("full buffer not retried");
  chk_timeout_error: assert property (@(posedge clk_i) disable iff (!rst_n)
    timeout |=> err_flag && load_addr == $past(load_addr))
    else $error("time-out did not set error");
  chk_err_read_clear: assert property (@(posedge clk_i) disable iff (!rst_n)
    rd_ctrl && !timeout |=> !err_flag)
    else $error("control read did not clear error");
  chk_decode_two: assert property (@(posedge clk_i) disable iff (!rst_n)
    io_sel_i && io_addr_i != FWL_OFS_DATA_ADDR && io_addr_i != FWL_OFS_CONTROL |-> io_unmapped_o)
    else $error("unmapped offset decoded");
  chk_reset_state: assert property (@(posedge clk_i)
    !rst_n |=> !addr_rst && !err_flag && !core_reset_n_o && clr_busy)
    else $error("reset did not clear loader");

  // Bus answers, read-back, control bits, core hold, queueing and the clear sweep
  chk_retry_holds_addr: assert property (@(posedge clk_i) disable iff (!rst_n)
    io_retry_o |=> load_addr == $past(load_addr))
    else $error("retried write moved load address");
  chk_timeout_restarts: assert property (@(posedge clk_i) disable iff (!rst_n)
    timeout |-> io_ack_o ##1 wait_cnt == FWL_WAIT_RESET)
    else $error("time-out did not end the retried write");
  chk_ctrl_read_value: assert property (@(posedge clk_i) disable iff (!rst_n)
    rd_ctrl |=> io_rdata_o == {31'h00000000, $past(err_flag)})
    else $error("control read did not return error flag");
  chk_unmapped_zero: assert property (@(posedge clk_i) disable iff (!rst_n)
    io_unmapped_o && !io_write_i |=> io_rdata_o == FWL_CONTROL_RESET)
    else $error("unmapped read not zero");
  chk_unmapped_acked: assert property (@(posedge clk_i) disable iff (!rst_n)
    io_unmapped_o |-> io_ack_o && !io_retry_o)
    else $error("unmapped access not acknowledged");
  chk_addr_never_retried: assert property (@(posedge clk_i) disable iff (!rst_n)
    wr_data && addr_rst |-> io_ack_o && !io_retry_o)
    else $error("address write was retried");
  chk_addr_rst_set: assert property (@(posedge clk_i) disable iff (!rst_n)
    wr_ctrl && io_wdata_i[FWL_BIT_ADDR_RST] |=> addr_rst)
    else $error("address-reset bit not taken");
  chk_program_holds_core: assert property (@(posedge clk_i) disable iff (!rst_n)
    wr_ctrl && io_wdata_i[FWL_BIT_PROGRAM] && !io_wdata_i[FWL_BIT_DONE] |=> program_flag && !core_reset_n_o)
    else $error("program bit did not hold core");
  chk_word_queued: assert property (@(posedge clk_i) disable iff (!rst_n)
    data_word_wr |=> fifo_out_valid)
    else $error("accepted word not queued");
  chk_clear_sweep_ends: assert property (@(posedge clk_i) disable iff (!rst_n)
    clr_busy && clr_addr == FWL_ADDR_LAST |=> !clr_busy)
    else $error("RAM clear sweep did not end");

  cov_address_then_data: cover property (@(posedge clk_i) disable iff (!rst_n)
    wr_data && addr_rst ##1 data_word_wr);
  cov_retry_seen: cover property (@(posedge clk_i) disable iff (!rst_n) io_retry_o);
  cov_timeout_seen: cover property (@(posedge clk_i) disable iff (!rst_n) timeout);
  cov_core_release: cover property (@(posedge clk_i) disable iff (!rst_n) $rose(core_reset_n_o));
  cov_error_cleared: cover property (@(posedge clk_i) disable iff (!rst_n) err_flag && rd_ctrl);

endmodule

// ---- tb/fwl_host.sv ----
/*
  Host driver model: masters the loader's I/O window one access at a time.
  Assumes stimulus changes at the falling edge and a combinational ack.
*/
`timescale 1ns/1ns
module fwl_host
  import fwl_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        io_ack_i,
  input  wire logic        io_unmapped_i,
  input  wire logic [31:0] io_rdata_i,
  output logic             io_sel_o,
  output logic             io_write_o,
  output logic [2:0]       io_addr_o,
  output logic [31:0]      io_wdata_o,
  output logic [3:0]       io_be_n_o
);
  // ==========================================================================
  // Idle bus: strobe low, qualifiers scrambled so stale values never pass
  initial begin
    io_sel_o   = 1'b0;
    io_write_o = 1'b0;
    io_addr_o  = 3'h0;
    io_wdata_o = 32'h00000000;
    io_be_n_o  = 4'hF;
  end

  task automatic release_bus();
    io_sel_o   = 1'b0;
    io_write_o = ~io_write_o;
    io_addr_o  = ~io_addr_o;
    io_wdata_o = ~io_wdata_o;
    io_be_n_o  = ~io_be_n_o;
  endtask

  task automatic idle();
    @(negedge clk_i);
    release_bus();
  endtask

  // ==========================================================================
  // Write held until acked; n counts refused edges, -1 when the bound runs out
  task automatic wr(input logic [2:0] a, input logic [31:0] d, output int n);
    n = 0;
    @(negedge clk_i);
    io_sel_o   = 1'b1;
    io_write_o = 1'b1;
    io_addr_o  = a;
    io_wdata_o = d;
    io_be_n_o  = 4'h0;
    @(posedge clk_i);
    while (io_ack_i !== 1'b1 && n < 1000) begin
      n++;
      @(posedge clk_i);
    end
    if (io_ack_i !== 1'b1) n = -1;
  endtask

  // Read: data is taken at the falling edge half a cycle after the accepting edge
  task automatic rd(input logic [2:0] a, output logic [31:0] d, output logic u);
    @(negedge clk_i);
    io_sel_o   = 1'b1;
    io_write_o = 1'b0;
    io_addr_o  = a;
    @(posedge clk_i);
    u = io_unmapped_i;
    @(negedge clk_i);
    d = io_rdata_i;
    release_bus();
  endtask
endmodule

// ---- tb/tb.sv ----
/*
  Self-checking bench for the firmware RAM loader.
  Assumes the host model drives the I/O window; runs inside the RAM clear sweep.
*/
`timescale 1ns/1ns
module tb;
  import fwl_pkg::*;
  logic                  clk_i;
  logic                  reset_n_i;
  logic                  global_reset_in_n_i;
  logic                  io_sel, io_write, io_ack, io_retry, io_unmapped;
  logic [2:0]            io_addr;
  logic [31:0]           io_wdata, io_rdata;
  logic [3:0]            io_be_n;
  logic                  core_reset_n, programming, load_error;
  logic [FWL_WORD_W-1:0] core_rdata;
  int                    failures;
  int                    samples_checked;
  int                    last_n;
  int                    retry_edges = 0;
  logic [FWL_ADDR_W-1:0] core_raddr;

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  fwl_loader i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .global_reset_in_n_i(global_reset_in_n_i),
    .io_sel_i(io_sel), .io_write_i(io_write), .io_addr_i(io_addr), .io_wdata_i(io_wdata),
    .io_be_n_i(io_be_n), .io_rdata_o(io_rdata), .io_ack_o(io_ack), .io_retry_o(io_retry),
    .io_unmapped_o(io_unmapped), .core_reset_n_o(core_reset_n), .programming_o(programming),
    .load_error_o(load_error), .core_raddr_i(core_raddr), .core_rdata_o(core_rdata));

  fwl_host i_host (.clk_i(clk_i), .io_ack_i(io_ack), .io_unmapped_i(io_unmapped), .io_rdata_i(io_rdata),
    .io_sel_o(io_sel), .io_write_o(io_write), .io_addr_o(io_addr), .io_wdata_o(io_wdata),
    .io_be_n_o(io_be_n));

  // Counts edges at which a write was refused with retry
  always @(posedge clk_i) begin
    if (io_retry === 1'b1) begin
      retry_edges <= retry_edges + 1;
    end
  end

  // ==========================================================================
  // Shared helpers
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    i_host.wr(a, d, last_n);
    if (last_n < 0) begin
      failures++;
      $display("mismatch write handshake expected ack seen none");
      tally_and_finish();
    end
  endtask

  // ==========================================================================
  // Scenarios
  task automatic s_reset_state();
    logic [31:0] r;
    logic        u;
    chk("core reset", 32'h0, 32'(core_reset_n));
    chk("programming", 32'h0, 32'(programming));
    chk("error flag", 32'h0, 32'(load_error));
    chk("RAM word 0 cleared", 32'h0, 32'(core_rdata));
    i_host.rd(FWL_OFS_CONTROL, r, u);
    chk("control read", FWL_CONTROL_RESET, r);
    core_raddr = 18'h00001;
    @(negedge clk_i);
    chk("RAM word 1 cleared", 32'h0, 32'(core_rdata));
  endtask

  task automatic s_decode();
    logic [31:0] r;
    logic        u;
    for (int a = 0; a < 8; a++) begin
      i_host.rd(3'(a), r, u);
      chk("unmapped flag", 32'(a != 0 && a != 4), 32'(u));
      chk("read value", (a == 0) ? FWL_DATA_READ_VALUE : 32'h0, r);
    end
  endtask

  task automatic s_core_hold();
    logic [31:0] r;
    logic        u;
    wr(FWL_OFS_CONTROL, 32'h00000002);
    i_host.idle();
    chk("programming", 32'h1, 32'(programming));
    chk("core held", 32'h0, 32'(core_reset_n));
    wr(FWL_OFS_CONTROL, 32'h00000004);
    i_host.idle();
    chk("core released", 32'h1, 32'(core_reset_n));
    i_host.rd(FWL_OFS_CONTROL, r, u);
    chk("write-only bits", 32'h0, r);
    wr(FWL_OFS_CONTROL, 32'h00000002);
    i_host.idle();
    chk("core held again", 32'h0, 32'(core_reset_n));
  endtask

  task automatic s_buffer_retry();
    logic [31:0] r;
    logic        u;
    int          base;
    wr(FWL_OFS_CONTROL, 32'h00000008);
    wr(FWL_OFS_DATA_ADDR, 32'h00000100);
    chk("address write retries", 32'h0, 32'(last_n));
    for (int i = 0; i < FWL_FIFO_DEPTH; i++) begin
      wr(FWL_OFS_DATA_ADDR, 32'(i));
      chk("buffered write retries", 32'h0, 32'(last_n));
    end
    // RAM is still being cleared, so the buffer stays full
    base = retry_edges;
    wr(FWL_OFS_DATA_ADDR, 32'h0000BEEF);
    chk("retries before timeout", 32'(FWL_RETRY_TIMEOUT_CYC - 1), 32'(last_n));
    i_host.idle();
    chk("retry strobes seen", 32'(FWL_RETRY_TIMEOUT_CYC - 1), 32'(retry_edges - base));
    chk("error flag set", 32'h1, 32'(load_error));
    i_host.rd(FWL_OFS_DATA_ADDR, r, u);
    chk("data read after writes", FWL_DATA_READ_VALUE, r);
    i_host.rd(FWL_OFS_CONTROL, r, u);
    chk("control read error", 32'h1, r);
    i_host.rd(FWL_OFS_CONTROL, r, u);
    chk("control read cleared", 32'h0, r);
    chk("error flag cleared", 32'h0, 32'(load_error));
  endtask

  task automatic s_global_reset();
    wr(FWL_OFS_CONTROL, 32'h00000004);
    i_host.idle();
    global_reset_in_n_i = 1'b0;
    repeat (4) @(negedge clk_i);
    global_reset_in_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    chk("core after pin reset", 32'h0, 32'(core_reset_n));
    chk("programming after pin reset", 32'h0, 32'(programming));
    wr(FWL_OFS_CONTROL, 32'h00000008);
    wr(FWL_OFS_DATA_ADDR, 32'h00000000);
    wr(FWL_OFS_DATA_ADDR, 32'h00001234);
    chk("buffer emptied by reset", 32'h0, 32'(last_n));
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    failures = 0;
    samples_checked = 0;
    reset_n_i = 1'b0;
    global_reset_in_n_i = 1'b1;
    core_raddr = FWL_ADDR_RESET;
    repeat (12) @(negedge clk_i);
    reset_n_i = 1'b1;
    // The pin synchroniser keeps the loader in reset for two more edges
    repeat (2) @(negedge clk_i);
    s_reset_state();
    s_decode();
    s_core_hold();
    s_buffer_retry();
    s_global_reset();
    tally_and_finish();
  end
endmodule
